// File: logic/stl_pkg.sv
// Package with register map, field codes and timing constants for torque limit selection.
package stl_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_NS  = 1_000_000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  localparam logic [3:0] ADDR_CMD_SRC   = 4'h0;
  localparam logic [3:0] ADDR_DIR_INV   = 4'h1;
  localparam logic [3:0] ADDR_SPD_LIM   = 4'h2;
  localparam logic [3:0] ADDR_DIG_TRQ   = 4'h3;
  localparam logic [3:0] ADDR_LIM_SRC   = 4'h4;
  localparam logic [3:0] ADDR_DET_DLY   = 4'h5;
  localparam logic [3:0] ADDR_INT_FWD   = 4'h6;
  localparam logic [3:0] ADDR_INT_REV   = 4'h7;
  localparam logic [3:0] ADDR_EXT_POS   = 4'h8;
  localparam logic [3:0] ADDR_EXT_REV   = 4'h9;
  localparam logic [3:0] ADDR_DI_CFG    = 4'hA;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'hB;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'hC;
  localparam logic [3:0] ADDR_STATUS    = 4'hD;
  localparam logic [15:0] RST_INT_FWD   = 16'h012C;
  localparam logic [15:0] RST_INT_REV   = 16'hFED4;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] MAX_PCT       = 16'h012C;
  localparam logic [15:0] MAX_DELAY_MS  = 16'h2710;
  localparam logic [3:0] FN_EXT_POS     = 4'h7;
  localparam logic [3:0] FN_EXT_REV     = 4'h8;
  localparam logic [2:0] LVL_LOW  = 3'h0;
  localparam logic [2:0] LVL_HIGH = 3'h1;
  localparam logic [2:0] LVL_RISE = 3'h2;
  localparam logic [2:0] LVL_FALL = 3'h3;
  localparam logic [2:0] LVL_BOTH = 3'h4;
  typedef enum logic [2:0] {
    STL_IDLE = 3'b001,
    STL_WAIT = 3'b010,
    STL_HIT  = 3'b100
  } stl_det_t;
endpackage

// File: logic/stl_torque_limit.sv
// Torque command source, limit selection, clamping and delayed limit detection.
//
// How it works
// R1: Command source 0,2 analog; 1,3 digital.
// R2: Sources 0,1 use speed limit parameter.
// R3: Inversion 1 reverses analog torque direction.
// R4: Speed capped at limit in torque mode.
// R5: Signed digital torque value, -300 to 300.
// R6: Limit source 0 uses internal/external parameters.
// R7: Limit source 1 uses analog magnitude both ways.
// R8: Limit source 2 uses digital torque value.
// R9: Detection output delayed 0 to 10000 ms.
// R10: Forward limit 0 to 300 percent.
// R11: Reverse limit -300 to 0 percent.
// R12: Reaching limit drives detection output.
// R13: Function 7 input selects external positive limit.
// R14: Function 8 input selects external reverse limit.
// R15: No assignment keeps internal limits.
// R16: Inputs valid by level or edge setting.
// R17: Clamp command; flag after full delay.
// R18: Drop flag below limit; restart timer.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module stl_torque_limit
  import stl_pkg::*;
#(
  parameter int unsigned N_DI      = 2,
  parameter int unsigned MS_CYC    = MS_CYCLES
)(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic [N_DI-1:0]    di_pin,
  input  wire logic               torque_mode,
  input  wire logic signed [15:0] analog_torque,
  input  wire logic signed [15:0] analog_speed,
  input  wire logic signed [15:0] actual_torque,
  output logic signed [15:0]      torque_cmd,
  output logic signed [15:0]      fwd_limit,
  output logic signed [15:0]      rev_limit,
  output logic signed [15:0]      speed_limit,
  output logic                    speed_limit_en,
  output logic                    limit_detect,
  output logic                    irq
);
  initial begin
    if (N_DI < 1 || N_DI > 4) $error("N_DI must be 1 to 4");
    if (MS_CYC < 1) $error("MS_CYC must be at least 1");
  end

  // Saturates a signed value into the range lo..hi.
  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v > hi) clamp16 = hi;
    else if (v < lo) clamp16 = lo;
    else clamp16 = v;
  endfunction

  // Magnitude of a signed value.
  function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? -v : v;
  endfunction

  // Reset release through two flip-flops.
  logic rst_m_q, rst_n_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // Parameter registers.
  logic [1:0]         cmd_src_q;
  logic               dir_inv_q;
  logic [15:0]        spd_lim_q;
  logic signed [15:0] dig_trq_q;
  logic [1:0]         lim_src_q;
  logic [15:0]        det_dly_q;
  logic signed [15:0] int_fwd_q, int_rev_q, ext_pos_q, ext_rev_q;
  logic [15:0]        di_cfg_q;
  logic [1:0]         irq_stat_q, irq_mask_q;

  wire wr_cmd = reg_wr && reg_addr == ADDR_CMD_SRC;
  wire wr_dir = reg_wr && reg_addr == ADDR_DIR_INV;
  wire wr_spd = reg_wr && reg_addr == ADDR_SPD_LIM;
  wire wr_dig = reg_wr && reg_addr == ADDR_DIG_TRQ;
  wire wr_lsr = reg_wr && reg_addr == ADDR_LIM_SRC;
  wire wr_dly = reg_wr && reg_addr == ADDR_DET_DLY;
  wire wr_ifw = reg_wr && reg_addr == ADDR_INT_FWD;
  wire wr_irv = reg_wr && reg_addr == ADDR_INT_REV;
  wire wr_epo = reg_wr && reg_addr == ADDR_EXT_POS;
  wire wr_erv = reg_wr && reg_addr == ADDR_EXT_REV;
  wire wr_dic = reg_wr && reg_addr == ADDR_DI_CFG;
  wire wr_msk = reg_wr && reg_addr == ADDR_IRQ_MASK;
  wire rd_stat = reg_rd && reg_addr == ADDR_IRQ_STAT;
  wire signed [15:0] pct_max = MAX_PCT;
  wire signed [15:0] pct_min = -pct_max;

  // Register writes; percentages and delay are saturated to their ranges.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_src_q  <= 2'h0;
      dir_inv_q  <= 1'b0;
      spd_lim_q  <= RST_ZERO;
      dig_trq_q  <= RST_ZERO;
      lim_src_q  <= 2'h0;
      det_dly_q  <= RST_ZERO;
      int_fwd_q  <= RST_INT_FWD;
      int_rev_q  <= RST_INT_REV;
      ext_pos_q  <= RST_INT_FWD;
      ext_rev_q  <= RST_INT_REV;
      di_cfg_q   <= RST_ZERO;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_cmd) cmd_src_q <= reg_wdata[1:0];
      if (wr_dir) dir_inv_q <= reg_wdata[0];
      if (wr_spd) spd_lim_q <= reg_wdata;
      if (wr_dig) dig_trq_q <= clamp16(reg_wdata, pct_min, pct_max); // R5
      if (wr_lsr) lim_src_q <= reg_wdata[1:0];
      if (wr_dly) det_dly_q <= (reg_wdata > MAX_DELAY_MS) ? MAX_DELAY_MS : reg_wdata; // R9
      if (wr_ifw) int_fwd_q <= clamp16(reg_wdata, 16'sh0000, pct_max); // R10
      if (wr_irv) int_rev_q <= clamp16(reg_wdata, pct_min, 16'sh0000); // R11
      if (wr_epo) ext_pos_q <= clamp16(reg_wdata, 16'sh0000, pct_max);
      if (wr_erv) ext_rev_q <= clamp16(reg_wdata, pct_min, 16'sh0000);
      if (wr_dic) di_cfg_q <= reg_wdata;
      if (wr_msk) irq_mask_q <= reg_wdata[1:0];
    end
  end

  // Input pins: two-flop synchroniser then a history flop for edges.
  logic [N_DI-1:0] di_s1_q, di_s2_q, di_prev_q;
  logic [2:0]      di_arm_q;
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      di_s1_q   <= '0;
      di_s2_q   <= '0;
      di_prev_q <= '0;
      di_arm_q  <= 3'h0;
    end else begin
      di_s1_q   <= di_pin;
      di_s2_q   <= di_s1_q;
      di_prev_q <= di_s2_q;
      di_arm_q  <= {di_arm_q[1:0], 1'b1};
    end
  end

  // Per-input validity, level setting and function; edge modes latch a toggle.
  // DI_CFG: input i uses bits [8i+2:8i] level, [8i+7:8i+4] function.
  logic [N_DI-1:0] di_tog_q;
  logic [N_DI-1:0] di_valid;
  logic [N_DI-1:0] di_fn_pos, di_fn_rev;
  logic [N_DI-1:0] di_edge;
  for (genvar i = 0; i < N_DI; i++) begin : g_di
    wire [2:0] lvl = di_cfg_q[8*i +: 3];
    wire [3:0] fn  = di_cfg_q[8*i+4 +: 4];
    wire rise = di_s2_q[i] & ~di_prev_q[i];
    wire fall = ~di_s2_q[i] & di_prev_q[i];
    assign di_edge[i] = (lvl == LVL_RISE) ? rise :
                        (lvl == LVL_FALL) ? fall :
                        (lvl == LVL_BOTH) ? (rise | fall) : 1'b0;
    assign di_valid[i] = (lvl == LVL_LOW)  ? ~di_s2_q[i] :
                         (lvl == LVL_HIGH) ?  di_s2_q[i] : di_tog_q[i]; // R16
    assign di_fn_pos[i] = (fn == FN_EXT_POS) && di_valid[i]; // R13
    assign di_fn_rev[i] = (fn == FN_EXT_REV) && di_valid[i]; // R14
  end

  // Edge-effective inputs flip their valid state on each qualifying edge.
  // Edges count only once the history flop holds a real sample, so a pin idling high
  // does not look like a rising edge just after reset.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) di_tog_q <= '0;
    else di_tog_q <= di_tog_q ^ (di_edge & {N_DI{di_arm_q[2]}}); // R16
  end

  // Command source and direction.
  wire sel_digital = cmd_src_q[0]; // R1
  wire signed [15:0] ana_cmd = dir_inv_q ? -analog_torque : analog_torque; // R3
  wire signed [15:0] raw_cmd = sel_digital ? dig_trq_q : ana_cmd; // R1 R5
  wire spd_from_param = ~cmd_src_q[1]; // R2
  wire signed [15:0] spd_next = spd_from_param ? $signed(spd_lim_q) : abs16(analog_speed); // R2 R4

  // Limit selection; with no input assigned the internal pair stays in use.
  wire ext_pos_sel = |di_fn_pos;
  wire ext_rev_sel = |di_fn_rev;
  wire signed [15:0] par_fwd = ext_pos_sel ? ext_pos_q : int_fwd_q; // R6 R13 R15
  wire signed [15:0] par_rev = ext_rev_sel ? -abs16(ext_rev_q) : int_rev_q; // R6 R14 R15
  wire signed [15:0] ana_mag = clamp16(abs16(analog_torque), 16'sh0000, pct_max);
  wire signed [15:0] dig_mag = abs16(dig_trq_q);
  wire signed [15:0] fwd_next = (lim_src_q == 2'h1) ? ana_mag : // R7
                                (lim_src_q == 2'h2) ? dig_mag : par_fwd; // R8
  wire signed [15:0] rev_next = (lim_src_q == 2'h1) ? -ana_mag : // R7
                                (lim_src_q == 2'h2) ? -dig_mag : par_rev; // R8
  wire signed [15:0] cmd_next = clamp16(raw_cmd, rev_next, fwd_next); // R17
  // Limits read zero during reset; the valid flag keeps that from looking like a hit.
  logic lim_vld_q;
  wire at_limit = lim_vld_q &&
                  ((actual_torque >= fwd_limit) || (actual_torque <= rev_limit)); // R12

  // Registered loop outputs, updated every cycle.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      torque_cmd     <= 16'sh0000;
      fwd_limit      <= 16'sh0000;
      rev_limit      <= 16'sh0000;
      speed_limit    <= 16'sh0000;
      speed_limit_en <= 1'b0;
      lim_vld_q      <= 1'b0;
    end else begin
      lim_vld_q      <= 1'b1;
      torque_cmd     <= cmd_next; // R17
      fwd_limit      <= fwd_next;
      rev_limit      <= rev_next;
      speed_limit    <= spd_next; // R4
      speed_limit_en <= torque_mode; // R4
    end
  end

  // Millisecond tick and detection delay machine.
  logic [$clog2(MS_CYC+1)-1:0] tick_cnt_q;
  logic [15:0] ms_cnt_q;
  stl_det_t    det_q, det_d;
  wire ms_tick = (tick_cnt_q == ($clog2(MS_CYC+1))'(MS_CYC - 1));
  wire dly_done = (ms_cnt_q >= det_dly_q);

  always_comb begin
    det_d = det_q;
    case (det_q)
      STL_IDLE: if (at_limit) det_d = dly_done ? STL_HIT : STL_WAIT; // R9
      STL_WAIT: begin
        if (!at_limit) det_d = STL_IDLE; // R18
        else if (dly_done) det_d = STL_HIT; // R17
      end
      STL_HIT:  if (!at_limit) det_d = STL_IDLE; // R18
      default:  det_d = STL_IDLE;
    endcase
  end

  // Delay counters restart whenever the machine is idle.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      det_q      <= STL_IDLE;
      tick_cnt_q <= '0;
      ms_cnt_q   <= 16'h0000;
      limit_detect <= 1'b0;
    end else begin
      det_q <= det_d;
      limit_detect <= (det_d == STL_HIT); // R12
      if (det_q != STL_WAIT) begin
        tick_cnt_q <= '0; // R18
        ms_cnt_q   <= 16'h0000;
      end else if (ms_tick) begin
        tick_cnt_q <= '0;
        ms_cnt_q   <= ms_cnt_q + 16'h0001; // R9
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // Interrupt: bit0 limit reached, bit1 limit released; read clears, set wins.
  wire [1:0] ev = {det_q == STL_HIT && det_d == STL_IDLE, det_q != STL_HIT && det_d == STL_HIT};
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | ev;
      irq        <= |(((rd_stat ? 2'h0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // Read data mux, one cycle after the strobe; unmapped reads zero.
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_CMD_SRC:  rd_mux = {14'h0000, cmd_src_q};
      ADDR_DIR_INV:  rd_mux = {15'h0000, dir_inv_q};
      ADDR_SPD_LIM:  rd_mux = spd_lim_q;
      ADDR_DIG_TRQ:  rd_mux = dig_trq_q;
      ADDR_LIM_SRC:  rd_mux = {14'h0000, lim_src_q};
      ADDR_DET_DLY:  rd_mux = det_dly_q;
      ADDR_INT_FWD:  rd_mux = int_fwd_q;
      ADDR_INT_REV:  rd_mux = int_rev_q;
      ADDR_EXT_POS:  rd_mux = ext_pos_q;
      ADDR_EXT_REV:  rd_mux = ext_rev_q;
      ADDR_DI_CFG:   rd_mux = di_cfg_q;
      ADDR_IRQ_STAT: rd_mux = {14'h0000, irq_stat_q};
      ADDR_IRQ_MASK: rd_mux = {14'h0000, irq_mask_q};
      ADDR_STATUS:   rd_mux = {13'h0000, ext_rev_sel, ext_pos_sel, limit_detect};
      default:       rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 16'h0000;
  end

  // Checks kept beside the logic.
  property p_cmd_clamped;
    @(posedge sys_clk) disable iff (!rst_n_q)
      torque_cmd <= fwd_limit && torque_cmd >= rev_limit;
  endproperty
  a_cmd_clamped: assert property (p_cmd_clamped) else $error("command outside limits"); // R17

  property p_drop;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (det_q == STL_HIT && !at_limit) |=> !limit_detect;
  endproperty
  a_drop: assert property (p_drop) else $error("detect not released"); // R18

  property p_lim_digital;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (lim_src_q == 2'h2) |=> fwd_limit == $past(dig_mag) && rev_limit == -$past(dig_mag);
  endproperty
  a_lim_digital: assert property (p_lim_digital) else $error("digital limit wrong"); // R8

  property p_lim_analog;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (lim_src_q == 2'h1) |=> fwd_limit == -rev_limit;
  endproperty
  a_lim_analog: assert property (p_lim_analog) else $error("analog limits not symmetric"); // R7

  property p_src_digital;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (sel_digital && dig_trq_q <= fwd_next && dig_trq_q >= rev_next) |=> torque_cmd == $past(dig_trq_q);
  endproperty
  a_src_digital: assert property (p_src_digital) else $error("digital source not used"); // R1

  property p_spd_param;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (!cmd_src_q[1]) |=> speed_limit == $past(spd_lim_q);
  endproperty
  a_spd_param: assert property (p_spd_param) else $error("speed limit source wrong"); // R2

  property p_delay;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (det_q == STL_WAIT && !dly_done) |=> !limit_detect;
  endproperty
  a_delay: assert property (p_delay) else $error("detect before delay"); // R9

  property p_fwd_range;
    @(posedge sys_clk) disable iff (!rst_n_q)
      int_fwd_q >= 0 && int_fwd_q <= pct_max && int_rev_q <= 0 && int_rev_q >= pct_min;
  endproperty
  a_fwd_range: assert property (p_fwd_range) else $error("internal limit out of range"); // R10
endmodule
`default_nettype wire

// File: verification/stl_loop_model.sv
// Behavioural torque loop that turns the clamped command into measured torque.
`timescale 1ns/1ns
`default_nettype none
module stl_loop_model (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               slow,
  input  wire logic signed [15:0] torque_cmd,
  output logic signed [15:0]      actual_torque
);
  logic signed [15:0] diff;
  logic               near;

  // Distance to the command decides whether a slow loop may land on it.
  assign diff = torque_cmd - actual_torque;
  assign near = (diff < 16'sd16) && (diff > -16'sd16);

  // Follows the command in one cycle, or ramps by 16 per cycle when slow.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      actual_torque <= 16'sh0000;
    end else if (!slow || near) begin
      actual_torque <= torque_cmd;
    end else begin
      actual_torque <= actual_torque + ((diff > 0) ? 16'sh0010 : 16'shFFF0);
    end
  end
endmodule
`default_nettype wire

// File: verification/servo_torque_limit_bench.sv
// Self-checking bench for command selection, limit selection and detection.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module servo_torque_limit_bench;
  import stl_pkg::*;
  logic               sys_clk = 1'b0;
  logic               resetn = 1'b0;
  logic [3:0]         reg_addr = 4'h0;
  logic [15:0]        reg_wdata = 16'h0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [15:0]        reg_rdata;
  logic [1:0]         di_pin = 2'h0;
  logic               torque_mode = 1'b1;
  logic               slow = 1'b0;
  logic signed [15:0] analog_torque = 16'sh0000;
  logic signed [15:0] analog_speed = 16'sh0000;
  logic signed [15:0] actual_torque, torque_cmd, fwd_limit, rev_limit, speed_limit;
  logic               speed_limit_en, limit_detect, irq;
  logic [15:0]        d, spd, dig;
  logic [2:0]         s;
  int                 err_total = 0;
  int                 check_count = 0;
  int                 seed = 74046;
  int                 n;

  // Clock at 100 MHz.
  always #5 sys_clk = ~sys_clk;

  stl_torque_limit #(.N_DI(2), .MS_CYC(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .di_pin(di_pin), .torque_mode(torque_mode),
    .analog_torque(analog_torque), .analog_speed(analog_speed),
    .actual_torque(actual_torque), .torque_cmd(torque_cmd), .fwd_limit(fwd_limit),
    .rev_limit(rev_limit), .speed_limit(speed_limit), .speed_limit_en(speed_limit_en),
    .limit_detect(limit_detect), .irq(irq));

  stl_loop_model i_loop (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
    .torque_cmd(torque_cmd), .actual_torque(actual_torque));

  // Magnitude saturated to the 0..300 percent range of a limit.
  function automatic logic [15:0] f_mag(input logic signed [15:0] v);
    logic signed [15:0] a;
    a = (v < 0) ? -v : v;
    return (a > 16'sd300) ? 16'h012C : a;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Counts cycles until the detection output reaches the wanted level.
  task automatic wait_det(input logic v, input int lo, input int hi);
    n = 0;
    while (limit_detect !== v && n < 60) begin
      settle(1);
      n++;
    end
    if (n == 60) begin
      err_total++;
      $display("BAD t=%0t detection wait ran out", $time);
      results();
    end else begin
      `CHK(n >= lo && n <= hi, 1'b1)
    end
  endtask

  initial begin
    settle(5);
    resetn = 1'b1;
    settle(3);
    // Reset values of parameter registers 0 to 9 and an unmapped place.
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], d);
      `CHK(d, (a == 6 || a == 8) ? RST_INT_FWD : (a == 7 || a == 9) ? RST_INT_REV : RST_ZERO)
    end
    wr(4'hE, 16'h1234);
    rd(4'hE, d);
    `CHK(d, 16'h0000)
    $display("test registers done");
    // Every command source with and without inversion, random operands.
    spd = $unsigned($random(seed)) % 6000;
    wr(ADDR_SPD_LIM, spd);
    rd(ADDR_SPD_LIM, d);
    `CHK(d, spd)
    for (int c = 0; c < 8; c++) begin
      dig = $signed($random(seed) % 200);
      @(posedge sys_clk);
      analog_torque <= $signed($random(seed) % 200);
      analog_speed <= $signed($random(seed) % 3000);
      torque_mode <= (c % 3 != 0);
      wr(ADDR_CMD_SRC, c / 2);
      wr(ADDR_DIR_INV, c % 2);
      wr(ADDR_DIG_TRQ, dig);
      settle(4);
      `CHK(torque_cmd, (c & 2) ? $signed(dig) : ((c & 1) ? -analog_torque : analog_torque))
      d = (analog_speed < 0) ? -analog_speed : analog_speed;
      `CHK(speed_limit, (c < 4) ? spd : d)
      `CHK(speed_limit_en, (c % 3 != 0))
    end
    $display("test command sources done");
    // Limit taken from the analog input and from the digital value.
    for (int c = 0; c < 4; c++) begin
      n = $unsigned($random(seed)) % 400 + 1;
      @(posedge sys_clk);
      analog_torque <= (c % 2) ? -n : n;
      wr(ADDR_LIM_SRC, 16'h0001);
      settle(4);
      `CHK(fwd_limit, f_mag(analog_torque))
      `CHK(rev_limit, -f_mag(analog_torque))
      dig = (c % 2) ? -(n % 300 + 1) : n % 300 + 1;
      wr(ADDR_DIG_TRQ, dig);
      wr(ADDR_LIM_SRC, 16'h0002);
      settle(4);
      `CHK(fwd_limit, f_mag(dig))
      `CHK(rev_limit, -f_mag(dig))
    end
    wr(ADDR_LIM_SRC, 16'h0000);
    wr(ADDR_DIG_TRQ, 16'h0000);
    wr(ADDR_EXT_POS, 16'h0096);
    wr(ADDR_EXT_REV, 16'hFF6A);
    $display("test limit sources done");
    // Each validity setting on input 0 with the external forward function.
    for (int l = 0; l < 5; l++) begin
      @(posedge sys_clk);
      di_pin <= 2'b00;
      settle(6);
      wr(ADDR_DI_CFG, {8'h00, 4'h7, 1'b0, l[2:0]});
      for (int k = 0; k < 3; k++) begin
        @(posedge sys_clk);
        di_pin[0] <= (k != 1);
        settle(6);
        s[k] = (fwd_limit === 16'sh0096);
      end
      if (l < 2) `CHK(s[0], l[0])
      `CHK(s[1] ^ s[0], (l != 2))
      `CHK(s[2] ^ s[1], (l != 3))
      `CHK(rev_limit, 16'shFED4)
    end
    // Both external functions selected, then both released.
    wr(ADDR_DI_CFG, 16'h8071);
    @(posedge sys_clk);
    di_pin <= 2'b01;
    settle(6);
    `CHK(fwd_limit, 16'sh0096)
    `CHK(rev_limit, 16'shFF6A)
    rd(ADDR_STATUS, d);
    `CHK(d, 16'h0006)
    @(posedge sys_clk);
    di_pin <= 2'b10;
    settle(6);
    `CHK(fwd_limit, 16'sh012C)
    `CHK(rev_limit, 16'shFED4)
    $display("test digital inputs done");
    // Clamp, immediate detection, interrupt and release.
    rd(ADDR_IRQ_STAT, d);
    wr(ADDR_INT_FWD, 16'h0064);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_DIG_TRQ, 16'h00C8);
    wait_det(1'b1, 1, 6);
    `CHK(torque_cmd, 16'sh0064)
    settle(2);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STAT, d);
    `CHK(d, 16'h0001)
    settle(2);
    `CHK(irq, 1'b0)
    wr(ADDR_DIG_TRQ, 16'h0000);
    wait_det(1'b0, 1, 5);
    rd(ADDR_IRQ_STAT, d);
    `CHK(d, 16'h0002)
    `CHK(irq, 1'b0)
    // Delayed detection with a slow loop waits the full delay after the limit is reached.
    slow <= 1'b1;
    wr(ADDR_DET_DLY, 16'h0002);
    wr(ADDR_INT_REV, 16'hFF9C);
    wr(ADDR_DIG_TRQ, 16'hFF38);
    `CHK(limit_detect, 1'b0)
    wait_det(1'b1, 15, 21);
    `CHK(torque_cmd, 16'shFF9C)
    `CHK(rev_limit, 16'shFF9C)
    $display("test detection done");
    results();
  end
endmodule
`default_nettype wire
